// *** sdcr_defs.svh ***
// Offsets, field positions, reset values and frame timing for the synthesizer config registers.
// Behaviour
// - Reference clock output drives only with its enable bit set and synthesizer enabled.
// - Reference clock output enable bit resets to one, no write needed.
// - Second divider code 0,1,2 gives divide by 1,2,4; code 3 reserved.
// - First divider code 0,1,2 gives divide by 5,4,3; code 3 reserved.
// - Third divider divides sampling clock by its 1 to 63 value, default 32.
// - Pre-emphasis field sets one level shared by every serial data lane.
`ifndef SDCR_DEFS_SVH
`define SDCR_DEFS_SVH

`define SDCR_ADDR_W         15
`define SDCR_FRAME_BITS     5'h18
`define SDCR_ADDR_DONE      5'h10

`define SDCR_OFS_REF_CTRL   15'h003C
`define SDCR_OFS_FBDIV_FS   15'h003D
`define SDCR_OFS_FBDIV_TH   15'h003E
`define SDCR_OFS_OSC_BIAS   15'h003F
`define SDCR_OFS_PREEMPH    15'h0048

`define SDCR_RST_REF_EN     1'h1
`define SDCR_RST_SECOND     2'h0
`define SDCR_RST_FIRST      2'h0
`define SDCR_RST_THIRD      6'h20
`define SDCR_RST_BIAS       7'h4F
`define SDCR_RST_PREEMPH    4'h0
`define SDCR_RST_RATIO1     3'h5
`define SDCR_RST_RATIO2     3'h1

`define SDCR_SECOND_MSB     3
`define SDCR_SECOND_LSB     2
`define SDCR_FIRST_MSB      1
`define SDCR_FIRST_LSB      0
`define SDCR_THIRD_MSB      5
`define SDCR_BIAS_MSB       6
`define SDCR_PREEMPH_MSB    3

`define SDCR_PIN_SCLK       0
`define SDCR_PIN_CSB        1
`define SDCR_PIN_SDI        2
`define SDCR_PIN_RST        3'h2

`endif

// *** sdcr_pkg.sv ***
// Types shared by the synthesizer config register block.
package sdcr_pkg;

   // Divider settings as applied to the synthesizer.
   typedef struct packed {
      logic [2:0] first_ratio;
      logic [2:0] second_ratio;
      logic [5:0] third_ratio;
   } sdcr_div_t;

   // Stored register fields.
   typedef struct packed {
      logic       ref_en;
      logic [1:0] second_code;
      logic [1:0] first_code;
      logic [5:0] third_code;
      logic [6:0] bias;
      logic [3:0] preemph;
   } sdcr_fields_t;

endpackage

// *** sdcr_top.sv ***
// Serial control port slave holding the synthesizer divider, bias and pre-emphasis registers.
`timescale 1ns/1ps
`default_nettype none
`include "sdcr_defs.svh"

// Frame on the serial port: chip select falls, then 24 rising clock edges carry a read flag,
// a 15-bit address and eight data bits, each field most significant bit first.
// Every pin passes three flip-flops and counts once the last two agree, so each serial
// clock phase must last at least two system clocks; faster activity is simply missed.
// A write commits on the 24th rising edge and reaches the outputs a clock later.
// A read loads the addressed register after the 16th rising edge and shifts it out on the
// following falling edges, with the data output enable high until chip select rises.
// An unmapped address is ignored on write and reads back as zero.
// Reserved bits are not stored and always read back as zero.
// Divider settings are stored at once but reach the synthesizer only while its reset bit
// is set, so a running loop never sees a half-changed ratio.
// There is no address increment: each frame moves exactly one byte.

module sdcr_top (
   input  wire logic               clk_i,
   input  wire logic               rst_b_i,
   input  wire logic               spi_sclk_i,
   input  wire logic               spi_csb_i,
   input  wire logic               spi_sdi_i,
   output logic                    spi_sdo_o,
   output logic                    spi_sdo_oe_o,
   input  wire logic               synth_enable_i,
   input  wire logic               synth_reset_bit_i,
   output logic                    ref_clock_out_en_o,
   output sdcr_pkg::sdcr_div_t     div_cfg_o,
   output logic [6:0]              oscillator_bias_o,
   output logic [3:0]              lane_preemphasis_level_o
);

   logic [2:0]               sync1_q;
   logic [2:0]               sync2_q;
   logic [2:0]               sync3_q;
   logic [2:0]               filt_q;
   logic [2:0]               agree;
   logic                     sclk_rise;
   logic                     sclk_fall;
   logic                     frame_start;
   logic [4:0]               cnt_q;
   logic [22:0]              shift_q;
   logic                     is_read_q;
   logic [7:0]               tx_q;
   logic [7:0]               wr_byte;
   logic [`SDCR_ADDR_W-1:0]  wr_addr;
   logic [4:0]               wr_sel;
   logic [4:0]               rd_sel;
   sdcr_pkg::sdcr_fields_t   regs_q;

   // Picks one of the five register offsets; bit order matches the read mux below.
   function automatic logic [4:0] reg_sel(input logic [`SDCR_ADDR_W-1:0] a);
      reg_sel = {a == `SDCR_OFS_PREEMPH, a == `SDCR_OFS_OSC_BIAS, a == `SDCR_OFS_FBDIV_TH,
                 a == `SDCR_OFS_FBDIV_FS, a == `SDCR_OFS_REF_CTRL};
   endfunction

   // Read value of a register; reserved bits return zero.
   function automatic logic [7:0] reg_read(input logic [4:0] s, input sdcr_pkg::sdcr_fields_t r);
      reg_read = 8'h00;
      case (1'b1)
         s[0]:    reg_read = {7'h00, r.ref_en};
         s[1]:    reg_read = {4'h0, r.second_code, r.first_code};
         s[2]:    reg_read = {2'h0, r.third_code};
         s[3]:    reg_read = {1'h0, r.bias};
         s[4]:    reg_read = {4'h0, r.preemph};
         default: reg_read = 8'h00;
      endcase
   endfunction

   // Second divider code to ratio; the reserved code maps to zero.
   function automatic logic [2:0] second_ratio(input logic [1:0] c);
      case (c)
         2'h0:    second_ratio = 3'h1;
         2'h1:    second_ratio = 3'h2;
         2'h2:    second_ratio = 3'h4;
         default: second_ratio = 3'h0;
      endcase
   endfunction

   // First divider code to ratio; the reserved code maps to zero.
   function automatic logic [2:0] first_ratio(input logic [1:0] c);
      case (c)
         2'h0:    first_ratio = 3'h5;
         2'h1:    first_ratio = 3'h4;
         2'h2:    first_ratio = 3'h3;
         default: first_ratio = 3'h0;
      endcase
   endfunction

   // Idle levels of the three pins, so that leaving reset raises no false edge.
   localparam logic [2:0] pin_rst = `SDCR_PIN_RST;

   // Three-stage pin synchronisers; a level counts once stages two and three agree.
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               sync1_q[g] <= pin_rst[g];
               sync2_q[g] <= pin_rst[g];
               sync3_q[g] <= pin_rst[g];
               filt_q[g]  <= pin_rst[g];
            end else begin
               sync1_q[g] <= (g == 0) ? spi_sclk_i : (g == 1) ? spi_csb_i : spi_sdi_i;
               sync2_q[g] <= sync1_q[g];
               sync3_q[g] <= sync2_q[g];
               if (agree[g]) begin
                  filt_q[g] <= sync2_q[g];
               end
            end
         end
         assign agree[g] = (sync2_q[g] == sync3_q[g]);
      end
   endgenerate

   // Edge events of the filtered pins.
   assign sclk_rise   = agree[`SDCR_PIN_SCLK] & sync2_q[`SDCR_PIN_SCLK] & ~filt_q[`SDCR_PIN_SCLK]
                        & ~filt_q[`SDCR_PIN_CSB];
   assign sclk_fall   = agree[`SDCR_PIN_SCLK] & ~sync2_q[`SDCR_PIN_SCLK] & filt_q[`SDCR_PIN_SCLK]
                        & ~filt_q[`SDCR_PIN_CSB];
   assign frame_start = agree[`SDCR_PIN_CSB] & ~sync2_q[`SDCR_PIN_CSB] & filt_q[`SDCR_PIN_CSB];
   assign wr_byte     = {shift_q[6:0], filt_q[`SDCR_PIN_SDI]};
   assign wr_addr     = shift_q[`SDCR_ADDR_W+6:7];

   // Register selects for the write address and for the read address as its last bit arrives.
   assign wr_sel      = reg_sel(wr_addr);
   assign rd_sel      = reg_sel({shift_q[`SDCR_ADDR_W-2:0], filt_q[`SDCR_PIN_SDI]});

   // Frame bit counter and command/address shifter; bits past the frame are ignored.
   // The counter stops at 24, so extra clock edges before chip select rises do nothing.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q     <= 5'h00;
         shift_q   <= 23'h000000;
         is_read_q <= 1'b0;
      end else if (frame_start) begin
         cnt_q <= 5'h00;
      end else if (sclk_rise && cnt_q != `SDCR_FRAME_BITS) begin
         cnt_q   <= cnt_q + 5'h01;
         shift_q <= {shift_q[21:0], filt_q[`SDCR_PIN_SDI]};
         if (cnt_q == 5'h00) begin
            is_read_q <= filt_q[`SDCR_PIN_SDI];
         end
      end
   end

   // Read data path: loaded after the address, shifted out on falling clock edges.
   // Bit seven leaves first, so the host takes it on the 17th rising edge.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_q         <= 8'h00;
         spi_sdo_o    <= 1'b0;
         spi_sdo_oe_o <= 1'b0;
      end else begin
         spi_sdo_oe_o <= is_read_q & ~filt_q[`SDCR_PIN_CSB] & (cnt_q >= `SDCR_ADDR_DONE);
         if (sclk_rise && cnt_q == `SDCR_ADDR_DONE - 5'h01) begin
            tx_q <= reg_read(rd_sel, regs_q);
         end else if (sclk_fall && cnt_q >= `SDCR_ADDR_DONE && cnt_q != `SDCR_FRAME_BITS) begin
            spi_sdo_o <= tx_q[7];
            tx_q      <= {tx_q[6:0], 1'b0};
         end
      end
   end

   // Register writes commit on the last data bit; reserved bits are not stored.
   // An unmapped address matches no select, so that frame changes nothing.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         regs_q.ref_en      <= `SDCR_RST_REF_EN;
         regs_q.second_code <= `SDCR_RST_SECOND;
         regs_q.first_code  <= `SDCR_RST_FIRST;
         regs_q.third_code  <= `SDCR_RST_THIRD;
         regs_q.bias        <= `SDCR_RST_BIAS;
         regs_q.preemph     <= `SDCR_RST_PREEMPH;
      end else if (sclk_rise && !is_read_q && cnt_q == `SDCR_FRAME_BITS - 5'h01) begin
         case (1'b1)
            wr_sel[0]: regs_q.ref_en <= wr_byte[0];
            wr_sel[1]: begin
               regs_q.second_code <= wr_byte[`SDCR_SECOND_MSB:`SDCR_SECOND_LSB];
               regs_q.first_code  <= wr_byte[`SDCR_FIRST_MSB:`SDCR_FIRST_LSB];
            end
            wr_sel[2]: regs_q.third_code <= wr_byte[`SDCR_THIRD_MSB:0];
            wr_sel[3]: regs_q.bias <= wr_byte[`SDCR_BIAS_MSB:0];
            wr_sel[4]: regs_q.preemph <= wr_byte[`SDCR_PREEMPH_MSB:0];
            default: regs_q <= regs_q;
         endcase
      end
   end

   // Divider settings reach the synthesizer only while it is held in reset.
   // A reserved code passes on as ratio zero, which the loop must never be released with.
   // Holding the last applied ratios keeps a running loop from seeing a partial update.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_cfg_o.first_ratio  <= `SDCR_RST_RATIO1;
         div_cfg_o.second_ratio <= `SDCR_RST_RATIO2;
         div_cfg_o.third_ratio  <= `SDCR_RST_THIRD;
      end else if (synth_reset_bit_i) begin
         div_cfg_o.first_ratio  <= first_ratio(regs_q.first_code);
         div_cfg_o.second_ratio <= second_ratio(regs_q.second_code);
         div_cfg_o.third_ratio  <= regs_q.third_code;
      end
   end

   // Analog controls and the reference output enable.
   // The reference output enable follows the synthesizer enable one clock later.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ref_clock_out_en_o       <= 1'b0;
         oscillator_bias_o        <= `SDCR_RST_BIAS;
         lane_preemphasis_level_o <= `SDCR_RST_PREEMPH;
      end else begin
         ref_clock_out_en_o       <= regs_q.ref_en & synth_enable_i;
         oscillator_bias_o        <= regs_q.bias;
         lane_preemphasis_level_o <= regs_q.preemph;
      end
   end

endmodule

`default_nettype wire

// *** sdcr_top_sva.sv ***
// Concurrent checks on the ports of the synthesizer config register block.
`timescale 1ns/1ps
`default_nettype none
module sdcr_top_sva (
   input wire logic                clk_i,
   input wire logic                rst_b_i,
   input wire logic                spi_csb_i,
   input wire logic                spi_sdo_oe_o,
   input wire logic                synth_enable_i,
   input wire logic                synth_reset_bit_i,
   input wire logic                ref_clock_out_en_o,
   input wire sdcr_pkg::sdcr_div_t div_cfg_o,
   input wire logic [6:0]          oscillator_bias_o,
   input wire logic [3:0]          lane_preemphasis_level_o
);
   // Every check runs on the system clock and pauses while reset is low.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // Output gating, boot default, divider decode and hold of stored fields.
   ref_gate_a: assert property (ref_clock_out_en_o |-> $past(synth_enable_i))
      else $error("ref clock out on while synth disabled");
   ref_boot_a: assert property ($rose(rst_b_i) && synth_enable_i |=> ref_clock_out_en_o)
      else $error("ref clock out not on after reset");
   second_code_a: assert property (div_cfg_o.second_ratio inside {3'h0, 3'h1, 3'h2, 3'h4})
      else $error("second ratio outside legal set");
   first_code_a: assert property (div_cfg_o.first_ratio inside {3'h0, 3'h3, 3'h4, 3'h5})
      else $error("first ratio outside legal set");
   div_hold_a: assert property (!synth_reset_bit_i |=> $stable(div_cfg_o))
      else $error("divider changed while synth not in reset");
   preemph_hold_a: assert property (spi_csb_i [*6] |=> $stable(lane_preemphasis_level_o))
      else $error("pre-emphasis changed outside a frame");
   bias_hold_a: assert property (spi_csb_i [*6] |=> $stable(oscillator_bias_o))
      else $error("bias changed outside a frame");
   sdo_idle_a: assert property (spi_csb_i [*6] |-> !spi_sdo_oe_o)
      else $error("data out driven while deselected");
   // Main scenarios reached.
   div_upd_c: cover property (synth_reset_bit_i && $changed(div_cfg_o));
   read_c: cover property ($rose(spi_sdo_oe_o));
   ref_off_c: cover property ($fell(ref_clock_out_en_o));
endmodule
bind sdcr_top sdcr_top_sva u_sva (.clk_i(clk_i), .rst_b_i(rst_b_i), .spi_csb_i(spi_csb_i),
   .spi_sdo_oe_o(spi_sdo_oe_o), .synth_enable_i(synth_enable_i),
   .synth_reset_bit_i(synth_reset_bit_i), .ref_clock_out_en_o(ref_clock_out_en_o),
   .div_cfg_o(div_cfg_o), .oscillator_bias_o(oscillator_bias_o),
   .lane_preemphasis_level_o(lane_preemphasis_level_o));
`default_nettype wire

// *** sdcr_top_tb_top.sv ***
// Self-checking testbench for the synthesizer config register block.
`timescale 1ns/1ps
`default_nettype none
module sdcr_top_tb_top;
   logic                clk_i = 1'h0;
   logic                rst_b_i = 1'h0;
   logic                sclk = 1'h0;
   logic                csb = 1'h1;
   logic                sdi = 1'h0;
   logic                sdo;
   logic                oe;
   logic                oe_seen = 1'h0;
   logic                en = 1'h1;
   logic                rb = 1'h0;
   logic                ref_o;
   sdcr_pkg::sdcr_div_t div;
   logic [6:0]          bias;
   logic [3:0]          pe;
   int                  num_errors = 0;
   int                  cmp_count = 0;
   // Clock of 100 ns period.
   always #50 clk_i = ~clk_i;
   sdcr_top u_sdcr_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .spi_sclk_i(sclk), .spi_csb_i(csb),
      .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(oe), .synth_enable_i(en),
      .synth_reset_bit_i(rb), .ref_clock_out_en_o(ref_o), .div_cfg_o(div),
      .oscillator_bias_o(bias), .lane_preemphasis_level_o(pe));
   // Compares a seen value with the expected one and counts both.
   task automatic chk(input logic [11:0] s, input logic [11:0] e);
      cmp_count++;
      if (s !== e) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // One serial frame; slow phases leave room for the input synchronisers.
   task automatic xfer(input logic rw, input logic [14:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      logic [23:0] f;
      f = {rw, a, d};
      q = 8'h00;
      @(posedge clk_i) csb <= 1'h0;
      for (int i = 23; i >= 0; i--) begin
         @(posedge clk_i) sdi <= f[i];
         sclk <= 1'h0;
         repeat (8) @(posedge clk_i);
         sclk <= 1'h1;
         if (i < 8) q[i] = sdo;
         if (i == 0) oe_seen = oe;
         repeat (8) @(posedge clk_i);
      end
      @(posedge clk_i) sclk <= 1'h0;
      repeat (8) @(posedge clk_i);
      csb <= 1'h1;
      repeat (8) @(posedge clk_i);
   endtask
   // Reset values at the divider and reference outputs and on read back.
   task automatic t_reset;
      logic [7:0]  q;
      logic [14:0] a [5] = '{15'h003C, 15'h003D, 15'h003E, 15'h003F, 15'h0048};
      logic [7:0]  e [5] = '{8'h01, 8'h00, 8'h20, 8'h4F, 8'h00};
      chk(div, {3'h5, 3'h1, 6'h20});
      chk(ref_o, 1'h1);
      for (int i = 0; i < 5; i++) begin
         xfer(1'h1, a[i], 8'h00, q);
         chk(q, e[i]);
         chk(oe_seen, 1'h1);
         chk(oe, 1'h0);
      end
      $display("t_reset done");
   endtask
   // Every divider code, third divider bounds and gating by the reset bit.
   task automatic t_div;
      logic [7:0] q;
      logic [2:0] fr [4] = '{3'h5, 3'h4, 3'h3, 3'h0};
      logic [2:0] sr [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
      rb <= 1'h1;
      for (int c = 0; c < 4; c++) begin
         xfer(1'h0, 15'h003D, {4'h0, c[1:0], c[1:0]}, q);
         chk(div.first_ratio, fr[c]);
         chk(div.second_ratio, sr[c]);
      end
      xfer(1'h0, 15'h003E, 8'h3F, q);
      chk(div.third_ratio, 6'h3F);
      xfer(1'h0, 15'h003E, 8'h01, q);
      chk(div.third_ratio, 6'h01);
      rb <= 1'h0;
      xfer(1'h0, 15'h003E, 8'h07, q);
      chk(div.third_ratio, 6'h01);
      xfer(1'h1, 15'h003E, 8'h00, q);
      chk(q, 8'h07);
      $display("t_div done");
   endtask
   // Reference output needs both its enable bit and the synthesizer enable.
   task automatic t_ref;
      logic [7:0] q;
      xfer(1'h0, 15'h003C, 8'h00, q);
      chk(ref_o, 1'h0);
      xfer(1'h0, 15'h003C, 8'h01, q);
      chk(ref_o, 1'h1);
      en <= 1'h0;
      repeat (3) @(posedge clk_i);
      chk(ref_o, 1'h0);
      en <= 1'h1;
      $display("t_ref done");
   endtask
   // Bias, global pre-emphasis, data output enable on a write and an unmapped address.
   task automatic t_misc;
      logic [7:0] q;
      xfer(1'h0, 15'h003F, 8'h4A, q);
      chk(bias, 7'h4A);
      xfer(1'h0, 15'h0048, 8'h0F, q);
      chk(pe, 4'hF);
      chk(oe_seen, 1'h0);
      xfer(1'h1, 15'h0048, 8'h00, q);
      chk(q, 8'h0F);
      xfer(1'h0, 15'h0040, 8'h55, q);
      xfer(1'h1, 15'h0040, 8'h00, q);
      chk(q, 8'h00);
      xfer(1'h1, 15'h003F, 8'h00, q);
      chk(q, 8'h4A);
      $display("t_misc done");
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Main sequence after 20 cycles of reset.
   initial begin
      repeat (20) @(posedge clk_i);
      rst_b_i <= 1'h1;
      repeat (6) @(posedge clk_i);
      t_reset();
      t_div();
      t_ref();
      t_misc();
      results();
   end
   // Watchdog well beyond the roughly 9000 cycles the tests need.
   initial begin
      repeat (40000) @(posedge clk_i);
      num_errors++;
      results();
   end
endmodule
`default_nettype wire
